// ### bench/rrgc_host_model.sv
`timescale 1ns/100ps
// host cpu on the serial command link; the link clock runs only inside a frame
module rrgc_host_model (
  // link pins
  output logic      link_sck,
  output logic      link_cs_n,
  output logic      link_di,
  // device status in, poll timeout flag out
  input  wire logic cmd_accept,
  output logic      poll_timeout
);
  // idle link: clock low, frame deselected
  initial begin
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    link_di = 1'b1;
    poll_timeout = 1'b0;
  end

  // one whole byte per frame, msb first; with poll set it waits for cmd_accept first
  task automatic send_byte(input logic [7:0] b, input bit poll);
    int n;
    n = 0;
    while (poll && cmd_accept !== 1'b1 && n < 500) begin
      #10;
      n++;
    end
    if (n >= 500) poll_timeout = 1'b1;
    #7 link_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link_di = b[i];
      #32 link_sck = 1'b1;
      #32 link_sck = 1'b0;
    end
    #16 link_cs_n = 1'b1;
    link_di = ~b[0]; // a released line must not show the stale bit
    #200; // spacing well above eight core cycles lets the effect settle
  endtask : send_byte
endmodule : rrgc_host_model

// ### bench/test_repeat_release_and_gain_control.sv
`timescale 1ns/100ps
`include "rrgc_defines.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_repeat_release_and_gain_control
  import rrgc_pkg::*;
;
  logic         core_clk, reset, play_active, pass_done, engine_hold, psel, penable, pwrite;
  logic [15:0]  remaining_samples;
  rrgc_method_e coding_method;
  rrgc_power_e  power_state;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, err, cmd_accept, repeat_mode, replay_next_pass;
  logic         end_after_pass, output_mute, stop_req, operand_valid;
  logic         link_sck, link_cs_n, link_di, poll_timeout;
  logic [3:0]   attenuation_code;
  logic [7:0]   operand_byte, op_last;
  rrgc_cdb_t    atten_cdb;
  int           error_cnt, samples_checked, stop_cnt;

  rrgc_top dut (.core_clk(core_clk), .reset(reset), .link_sck(link_sck),
    .link_cs_n(link_cs_n), .link_di(link_di), .play_active(play_active),
    .pass_done(pass_done), .remaining_samples(remaining_samples),
    .coding_method(coding_method), .power_state(power_state), .engine_hold(engine_hold),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_accept(cmd_accept),
    .repeat_mode(repeat_mode), .replay_next_pass(replay_next_pass),
    .end_after_pass(end_after_pass), .attenuation_code(attenuation_code),
    .output_mute(output_mute), .atten_cdb(atten_cdb), .stop_req(stop_req),
    .operand_valid(operand_valid), .operand_byte(operand_byte));
  rrgc_host_model host (.link_sck(link_sck), .link_cs_n(link_cs_n), .link_di(link_di),
    .cmd_accept(cmd_accept), .poll_timeout(poll_timeout));

  // core clock, 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // one-cycle pulses are caught here so the sequence can look at them later
  always @(posedge core_clk) begin
    if (stop_req === 1'b1) stop_cnt++;
    if (operand_valid === 1'b1) op_last = operand_byte;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // apb transfer; holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // a hang in the host poll or the whole run ends in the closing report
  always @(posedge poll_timeout) begin
    error_cnt++;
    report_and_stop();
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {reset, play_active, pass_done, engine_hold, psel, penable, pwrite} = 7'h41;
    {remaining_samples, paddr, pwdata} = '0;
    coding_method = RRGC_ADPCM4;
    power_state = RRGC_PWR_ON;
    {reset, play_active} = 2'h2;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    `CHK(attenuation_code, `RRGC_ATTEN_RESET)
    `CHK(cmd_accept, 1'b1)
    apb(1'b0, `RRGC_ADDR_CTRL, 32'h0);
    `CHK(rd, `RRGC_CTRL_RESET)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `RRGC_ADDR_GAIN, 32'h7);
    apb(1'b0, `RRGC_ADDR_GAIN, 32'h0);
    `CHK(rd[3:0], 4'h0)
    // a disabled port drops the byte, so the gain stays at 0 dB
    apb(1'b1, `RRGC_ADDR_CTRL, 32'h0);
    host.send_byte(8'hA5, 1'b1);
    `CHK(attenuation_code, 4'h0)
    apb(1'b0, `RRGC_ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, `RRGC_ADDR_CTRL, `RRGC_CTRL_RESET);
    $display("test reset_and_registers done");
    // every attenuation code, including the mute code
    for (int c = 0; c < 16; c++) begin
      host.send_byte({`RRGC_OP_GAIN, 4'(c)}, 1'b1);
      `CHK(attenuation_code, 4'(c))
      `CHK(output_mute, c == 15)
      if (c == 14) `CHK(atten_cdb, 12'hD46)
    end
    `CHK(atten_cdb, 12'h000)
    $display("test gain_codes done");
    // gain refused outside the on state, kept over power-down and stop
    host.send_byte(8'hA3, 1'b1);
    // playback over before any power-down: idle, accepting, powered on
    apb(1'b0, `RRGC_ADDR_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0082)
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      power_state <= rrgc_power_e'(p);
      host.send_byte(8'hA9, 1'b1);
      `CHK(attenuation_code, (p == 2) ? 4'h9 : 4'h3)
      host.send_byte(8'hA3, 1'b1);
    end
    // back to the on state, so an operand wrongly decoded as gain would show
    @(posedge core_clk);
    power_state <= RRGC_PWR_ON;
    host.send_byte(8'h40, 1'b1);
    host.send_byte(8'hA7, 1'b1);
    `CHK(op_last, 8'hA7)
    host.send_byte(8'h60, 1'b1);
    `CHK(attenuation_code, 4'h3)
    `CHK(stop_cnt, 1)
    $display("test gain_retention done");
    // release at the threshold and one sample below it, for every coding method
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      coding_method <= rrgc_method_e'(k / 2);
      play_active <= 1'b1;
      remaining_samples <= ((k < 2) ? 16'd35 : 16'd18) - 16'(k % 2);
      host.send_byte({`RRGC_OP_REPEAT_SET, 4'h0}, 1'b1);
      `CHK(repeat_mode, 1'b1)
      `CHK(cmd_accept, 1'b0)
      host.send_byte({`RRGC_OP_GAIN, 4'(k)}, 1'b0);
      `CHK(attenuation_code, 4'(k))
      host.send_byte({`RRGC_OP_REPEAT_REL, 4'(15 - k)}, 1'b0);
      `CHK(repeat_mode, 1'b0)
      `CHK(cmd_accept, 1'b1)
      `CHK(end_after_pass, k % 2 == 0)
      `CHK(replay_next_pass, k % 2 == 1)
      @(posedge core_clk);
      pass_done <= 1'b1;
      @(posedge core_clk);
      pass_done <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK(end_after_pass, k % 2 == 1)
      `CHK(replay_next_pass, 1'b0)
      play_active <= 1'b0;
    end
    $display("test repeat_release done");
    // stop clears repeat mode; engine hold alone lowers cmd_accept
    @(posedge core_clk);
    play_active <= 1'b1;
    host.send_byte({`RRGC_OP_REPEAT_SET, 4'h0}, 1'b1);
    host.send_byte({`RRGC_OP_STOP, 4'h0}, 1'b0);
    `CHK(repeat_mode, 1'b0)
    `CHK(cmd_accept, 1'b1)
    `CHK(stop_cnt, 2)
    @(posedge core_clk);
    engine_hold <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CHK(cmd_accept, 1'b0)
    $display("test stop_clears_repeat done");
    report_and_stop();
  end
endmodule : test_repeat_release_and_gain_control

// ### design/rrgc_defines.svh
`ifndef RRGC_DEFINES_SVH
`define RRGC_DEFINES_SVH

// command opcodes, upper nibble of the first byte
`define RRGC_OP_PLAY        4'h4
`define RRGC_OP_STOP        4'h6
`define RRGC_OP_SILENCE     4'h7
`define RRGC_OP_REPEAT_SET  4'h8
`define RRGC_OP_REPEAT_REL  4'h9
`define RRGC_OP_GAIN        4'hA

// remaining-sample thresholds for the release decision
`define RRGC_THR_ADPCM      16'h0023
`define RRGC_THR_PCM        16'h0012

// attenuation codes: reset value and mute code
`define RRGC_ATTEN_RESET    4'h0
`define RRGC_ATTEN_MUTE     4'hF

// apb register byte offsets
`define RRGC_ADDR_STATUS    12'h000
`define RRGC_ADDR_GAIN      12'h004
`define RRGC_ADDR_CTRL      12'h008

// control register fields
`define RRGC_CTRL_PORT_EN   0
`define RRGC_CTRL_RESET     32'h0000_0001

`endif

// ### design/rrgc_pkg.sv
package rrgc_pkg;

  // coding method of the phrase now playing
  typedef enum logic [1:0] {
    RRGC_ADPCM4,
    RRGC_PCM8,
    RRGC_PCM8_NL,
    RRGC_PCM16
  } rrgc_method_e;

  // power state reported by the power sequencer
  typedef enum logic [1:0] {
    RRGC_PWR_DOWN,
    RRGC_PWR_WAKING,
    RRGC_PWR_ON,
    RRGC_PWR_SLEEPING
  } rrgc_power_e;

  typedef logic [11:0] rrgc_cdb_t;

endpackage : rrgc_pkg

// ### design/rrgc_serial_rx.sv
`timescale 1ns/100ps
// shifts command bytes in on the link clock, msb first, while the select is low
module rrgc_serial_rx
  import rrgc_pkg::*;
(
  // link side
  input  wire logic       link_sck,
  input  wire logic       link_cs_n,
  input  wire logic       link_di,
  // reset
  input  wire logic       reset,
  // toward the core domain
  output logic      [7:0] rx_byte_reg,
  output logic            rx_toggle_reg
);

  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;

  // a raised select ends the frame, so a partial byte never leaks into the next one
  always_ff @(posedge link_sck or posedge link_cs_n or posedge reset) begin
    if (reset || link_cs_n) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg   <= {shift_reg[5:0], link_di};
    end
  end

  // whole byte held stable for eight link clocks, long enough for the core to copy it
  always_ff @(posedge link_sck or posedge reset) begin
    if (reset) begin
      rx_byte_reg   <= 8'h00;
      rx_toggle_reg <= 1'b0;
    end else if (!link_cs_n && bit_cnt_reg == 3'h7) begin
      rx_byte_reg   <= {shift_reg, link_di};
      rx_toggle_reg <= ~rx_toggle_reg;
    end
  end

endmodule : rrgc_serial_rx

// ### design/rrgc_top.sv
`timescale 1ns/100ps
`include "rrgc_defines.svh"
// Behaviour
// - opcode 1001 leaves repeat mode; low nibble ignored.
// - clearing repeat mode raises cmd_accept unless engine_hold is high.
// - release taken during playback whatever cmd_accept shows; host keeps spacing.
// - adpcm: 35 or more samples left ends this pass, else one more.
// - 8/16-bit pcm: 18 or more left ends this pass, else one more.
// - opcode 1010 loads low nibble as attenuation_code, bit 3 msb.
// - gain taken whatever cmd_accept shows; host keeps spacing.
// - gain ignored while down, waking or going down.
// - sixteen steps, 0 dB at 0000 to -33.98 dB; 1111 mutes.
// - attenuation_code is 0 dB after reset.
// - attenuation kept over power-down and stop; only gain or reset change it.
// - play and silence take two bytes; others one; operand only after those.
// - opcode 1000 enters repeat mode during playback.
// - cmd_accept held low while repeat mode is active.
// - stop also clears repeat mode.
module rrgc_top
  import rrgc_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // serial command link
  input  wire logic         link_sck,
  input  wire logic         link_cs_n,
  input  wire logic         link_di,
  // playback engine and power sequencer status, same clock
  input  wire logic         play_active,
  input  wire logic         pass_done,
  input  wire logic  [15:0] remaining_samples,
  input  wire rrgc_method_e coding_method,
  input  wire rrgc_power_e  power_state,
  input  wire logic         engine_hold,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic  [11:0] paddr,
  input  wire logic  [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // command results
  output logic              cmd_accept,
  output logic              repeat_mode,
  output logic              replay_next_pass,
  output logic              end_after_pass,
  output logic        [3:0] attenuation_code,
  output logic              output_mute,
  output rrgc_cdb_t         atten_cdb,
  output logic              stop_req,
  output logic              operand_valid,
  output logic        [7:0] operand_byte
);

  // threshold of remaining samples for the phrase's coding method
  function automatic logic [15:0] rel_threshold(input rrgc_method_e m);
    return (m == RRGC_ADPCM4) ? `RRGC_THR_ADPCM : `RRGC_THR_PCM;
  endfunction : rel_threshold

  // attenuation in hundredths of a dB, step 15 reports zero because it mutes
  function automatic rrgc_cdb_t code_to_cdb(input logic [3:0] c);
    case (c)
      4'h0:    return 12'h000;
      4'h1:    return 12'h03F;
      4'h2:    return 12'h083;
      4'h3:    return 12'h0CD;
      4'h4:    return 12'h11D;
      4'h5:    return 12'h176;
      4'h6:    return 12'h1D9;
      4'h7:    return 12'h249;
      4'h8:    return 12'h2C9;
      4'h9:    return 12'h360;
      4'hA:    return 12'h415;
      4'hB:    return 12'h4FC;
      4'hC:    return 12'h638;
      4'hD:    return 12'h82A;
      4'hE:    return 12'hD46;
      default: return 12'h000;
    endcase
  endfunction : code_to_cdb

  logic [7:0] rx_byte_reg;
  logic       rx_toggle_reg;
  logic [2:0] tog_sync_reg;
  logic [7:0] cmd_byte_reg;
  logic       byte_evt_reg;
  logic       operand_wait_reg;
  logic       port_en_reg;
  logic       repeat_mode_reg;
  logic       extra_pass_reg;
  logic       end_after_reg;
  logic [3:0] atten_reg;
  logic       cmd_evt;
  logic [3:0] op;
  logic       is_rel;
  logic       is_set;
  logic       is_stop;
  logic       is_gain;
  logic       repeat_next;
  logic       apb_access;
  logic       apb_hit;

  rrgc_serial_rx u_rx (
    .link_sck      (link_sck),
    .link_cs_n     (link_cs_n),
    .link_di       (link_di),
    .reset         (reset),
    .rx_byte_reg   (rx_byte_reg),
    .rx_toggle_reg (rx_toggle_reg)
  );

  // toggle crossing; the edge is taken between the second and third stage only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tog_sync_reg <= 3'h0;
    end else begin
      tog_sync_reg <= {tog_sync_reg[1:0], rx_toggle_reg};
    end
  end

  // the byte is quasi-static here: it changes with the toggle, then holds at least eight link clocks
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd_byte_reg <= 8'h00;
      byte_evt_reg <= 1'b0;
    end else begin
      byte_evt_reg <= (tog_sync_reg[2] ^ tog_sync_reg[1]) & port_en_reg;
      if (tog_sync_reg[2] ^ tog_sync_reg[1]) begin
        cmd_byte_reg <= rx_byte_reg;
      end
    end
  end

  // decode of a first byte
  assign op      = cmd_byte_reg[7:4];
  assign cmd_evt = byte_evt_reg & ~operand_wait_reg;
  assign is_rel  = cmd_evt && op == `RRGC_OP_REPEAT_REL;
  assign is_set  = cmd_evt && op == `RRGC_OP_REPEAT_SET;
  assign is_stop = cmd_evt && op == `RRGC_OP_STOP;
  assign is_gain = cmd_evt && op == `RRGC_OP_GAIN;

  // a two-byte opcode arms the operand slot; its operand is passed on, not decoded
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      operand_wait_reg <= 1'b0;
      operand_valid    <= 1'b0;
      operand_byte     <= 8'h00;
    end else begin
      operand_valid <= byte_evt_reg & operand_wait_reg;
      if (byte_evt_reg && operand_wait_reg) begin
        operand_wait_reg <= 1'b0;
        operand_byte     <= cmd_byte_reg;
      end else if (cmd_evt && (op == `RRGC_OP_PLAY || op == `RRGC_OP_SILENCE)) begin
        operand_wait_reg <= 1'b1;
      end
    end
  end

  // repeat mode: release and stop win over a set in the same byte (they cannot coincide)
  always_comb begin
    repeat_next = repeat_mode_reg;
    if (is_rel || is_stop) begin
      repeat_next = 1'b0;
    end else if (is_set && play_active) begin
      repeat_next = 1'b1;
    end else if (!play_active) begin
      repeat_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      repeat_mode_reg <= 1'b0;
      cmd_accept      <= 1'b1;
      stop_req        <= 1'b0;
    end else begin
      repeat_mode_reg <= repeat_next;
      cmd_accept      <= ~repeat_next & ~engine_hold;
      stop_req        <= is_stop;
    end
  end

  // release decision latched from the count seen when the byte is decoded
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      extra_pass_reg <= 1'b0;
      end_after_reg  <= 1'b0;
    end else if (is_stop || !play_active) begin
      extra_pass_reg <= 1'b0;
      end_after_reg  <= 1'b0;
    end else if (is_rel && repeat_mode_reg) begin
      if (remaining_samples >= rel_threshold(coding_method)) begin
        end_after_reg  <= 1'b1;
        extra_pass_reg <= 1'b0;
      end else begin
        extra_pass_reg <= 1'b1;
        end_after_reg  <= 1'b0;
      end
    end else if (pass_done && extra_pass_reg) begin
      extra_pass_reg <= 1'b0; // the extra pass starts now and is the last
      end_after_reg  <= 1'b1;
    end else if (pass_done) begin
      end_after_reg  <= 1'b0;
    end
  end

  // replay flag seen by the engine at each pass end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      replay_next_pass <= 1'b0;
      end_after_pass   <= 1'b0;
      repeat_mode      <= 1'b0;
    end else begin
      replay_next_pass <= repeat_mode_reg | extra_pass_reg;
      end_after_pass   <= end_after_reg;
      repeat_mode      <= repeat_mode_reg;
    end
  end

  // gain: kept over power-down and stop, loaded only by a gain byte while powered
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      atten_reg <= `RRGC_ATTEN_RESET;
    end else if (is_gain && power_state == RRGC_PWR_ON) begin
      atten_reg <= cmd_byte_reg[3:0];
    end
  end

  // gain outputs follow the stored code one cycle later
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      attenuation_code <= `RRGC_ATTEN_RESET;
      output_mute      <= 1'b0;
      atten_cdb        <= 12'h000;
    end else begin
      attenuation_code <= atten_reg;
      output_mute      <= atten_reg == `RRGC_ATTEN_MUTE;
      atten_cdb        <= code_to_cdb(atten_reg);
    end
  end

  // apb: one wait state so that prdata and pready come from flops
  assign apb_access = psel & penable;
  assign apb_hit    = paddr == `RRGC_ADDR_STATUS || paddr == `RRGC_ADDR_GAIN ||
                      paddr == `RRGC_ADDR_CTRL;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access & ~pready;
      pslverr <= apb_access & ~pready & ~apb_hit;
      prdata  <= 32'h0000_0000;
      if (apb_access && !pready && !pwrite) begin
        case (paddr)
          `RRGC_ADDR_STATUS: prdata <= {24'h000000, power_state, operand_wait_reg,
                                        end_after_reg, extra_pass_reg,
                                        repeat_mode_reg, cmd_accept, play_active};
          `RRGC_ADDR_GAIN:   prdata <= {15'h0000, output_mute, atten_cdb, atten_reg};
          `RRGC_ADDR_CTRL:   prdata <= {31'h00000000, port_en_reg};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control: a disabled port drops incoming bytes, useful while the host is rebooting
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_en_reg <= 1'(`RRGC_CTRL_RESET >> `RRGC_CTRL_PORT_EN);
    end else if (apb_access && pready && pwrite && paddr == `RRGC_ADDR_CTRL) begin
      port_en_reg <= pwdata[`RRGC_CTRL_PORT_EN];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_rel_repeat;
    is_rel && repeat_mode_reg && play_active;
  endsequence

  sequence s_two_byte_op;
    cmd_evt && (op == `RRGC_OP_PLAY || op == `RRGC_OP_SILENCE);
  endsequence

  sequence s_operand_byte;
    byte_evt_reg && operand_wait_reg;
  endsequence

  a_release_clears: assert property (is_rel |=> !repeat_mode_reg)
    else $error("repeat mode survived a release");
  a_release_accept: assert property (is_rel && !engine_hold |=> cmd_accept)
    else $error("cmd_accept not raised after release");
  a_adpcm_end: assert property (s_rel_repeat ##0 (coding_method == RRGC_ADPCM4 &&
    remaining_samples >= 16'h0023) |=> end_after_reg && !extra_pass_reg)
    else $error("adpcm release with enough samples did not end pass");
  a_adpcm_extra: assert property (s_rel_repeat ##0 (coding_method == RRGC_ADPCM4 &&
    remaining_samples < 16'h0023) |=> extra_pass_reg ##1 replay_next_pass)
    else $error("adpcm late release did not grant one more pass");
  a_pcm_decide: assert property (s_rel_repeat ##0 (coding_method != RRGC_ADPCM4) |=>
    (end_after_reg == ($past(remaining_samples) >= 16'h0012)))
    else $error("pcm release decision wrong");
  a_gain_load: assert property (is_gain && power_state == RRGC_PWR_ON |=>
    atten_reg == $past(cmd_byte_reg[3:0]) ##1 attenuation_code == atten_reg)
    else $error("gain code not loaded");
  a_gain_ignored: assert property (is_gain && power_state != RRGC_PWR_ON |=>
    $stable(atten_reg))
    else $error("gain changed while not powered");
  a_gain_mute: assert property (atten_reg == 4'hF |=> output_mute && atten_cdb == 12'h000)
    else $error("code 1111 did not mute");
  a_gain_reset: assert property ($fell(reset) |-> atten_reg == 4'h0)
    else $error("gain not 0 dB after reset");
  a_gain_keep: assert property (!is_gain |=> $stable(atten_reg))
    else $error("gain changed without a gain command");
  a_operand_arm: assert property (s_two_byte_op |=> operand_wait_reg)
    else $error("two-byte opcode did not arm the operand slot");
  a_operand_skip: assert property (s_operand_byte |=> operand_valid && !stop_req &&
    !operand_wait_reg && operand_byte == $past(cmd_byte_reg))
    else $error("operand byte decoded as a command");
  a_set_enter: assert property (is_set && play_active |=> repeat_mode_reg)
    else $error("repeat set ignored during playback");
  a_repeat_busy: assert property (repeat_mode_reg |-> !cmd_accept)
    else $error("cmd_accept high in repeat mode");
  a_stop_clears: assert property (is_stop |=> !repeat_mode_reg && !extra_pass_reg)
    else $error("stop left repeat state");

endmodule : rrgc_top
